// File: hdl/bdac_pkg.sv
// Purpose: shared constants for the burst dma address controller
// Assumes: byte-wide processor register port, one index bit
// Notes:   state codes follow the four-bit output encoding
package bdac_pkg;

  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned DATA_W       = 8;

  // register index bit values
  localparam logic        IDX_LOW      = 1'h1;
  localparam logic        IDX_HIGH     = 1'h0;

  // field positions in start_addr_high_ctrl
  localparam int unsigned F_HI_ADDR_LSB = 0;
  localparam int unsigned F_RUN         = 4;
  localparam int unsigned F_START_LOAD  = 5;
  localparam int unsigned F_COUNT_DIR   = 6;
  localparam int unsigned F_STATE_RST   = 7;

  // field positions in current_addr_high_status
  localparam int unsigned F_FAULT       = 4;

  // reset values
  localparam logic [7:0]  START_LOW_RST  = 8'h00;
  localparam logic [7:0]  START_HIGH_RST = 8'h00;
  localparam logic [11:0] END_ADDR_RST   = 12'hfff;

  // count direction: high steps up
  localparam logic        DIR_UP        = 1'h1;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_PRELOAD = 4'h1,
    ST_BUSREQ  = 4'h8,
    ST_MOVING  = 4'hc,
    ST_FAULT   = 4'h2
  } bdac_state_e;

endpackage

// File: hdl/bdac_addr_counter.sv
// Purpose: loadable up/down address counter with end comparator
// Assumes: same clock and reset as the controller
// Notes:   terminal count is registered
`timescale 1ns/1ps
`default_nettype none
module bdac_addr_counter (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        counterLoad,
  input  wire logic        transferAck,
  input  wire logic        countDirection,
  input  wire logic [11:0] startAddr,
  input  wire logic [11:0] endAddr,
  output logic [11:0]      addrCount,
  output logic             terminalCount
);

  logic [11:0] addr_next;

  always_comb begin
    addr_next = addrCount;
    if (counterLoad) begin
      addr_next = startAddr;
    end else if (transferAck) begin
      if (countDirection == bdac_pkg::DIR_UP) begin
        addr_next = addrCount + 12'h001;
      end else begin
        addr_next = addrCount - 12'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addrCount <= 12'h000;
    end else begin
      addrCount <= addr_next;
    end
  end

  // terminal count when the address being issued is the last one
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      terminalCount <= 1'b0;
    end else begin
      terminalCount <= !counterLoad && transferAck && (addr_next == endAddr)
                       && !terminalCount;
    end
  end

  a_count_hold : assert property (@(posedge clk) disable iff (!nrst)
    (!counterLoad && !transferAck) |=> $stable(addrCount))
    else $error("address counter moved without acknowledge");

endmodule
`default_nettype wire

// File: hdl/bdac_top.sv
// Purpose: burst dma address controller, register port plus control machine
// Assumes: strobes and peripheral inputs are asynchronous to clk
// Notes:   ending address has no printed register and is a port
//
// Operation
// - control write on write strobe rise with select, write, no read strobe
// - status read while read strobe, select low, read high, no write strobe
// - first control register holds start address low byte
// - second holds address bits 11..8, run, start load, direction, state reset
// - counter steps in direction given by count direction bit
// - first status register returns current address low byte
// - second status returns address high nibble and fault flag
// - data bus driven only while read strobe is active
// - four state bits: request, acknowledge, fault, counter load
// - machine idles at reset and on register state reset
// - idle to preload when run and start load both set
// - preload back to idle without run; to request on request, no start load
// - counter load high loads the 12-bit start address each edge
// - bus request state: fault on request drop, moving on grant
// - moving: terminal count to idle first, else fault on request drop
// - fault holds until state reset, then idle
// - counter advances only with acknowledge and no load
// - comparator raises terminal count at the ending address
// - low 12 address bits from loadable counter, driven through buffer
// - data strobe toggles each clock in transfer (one period per two clocks), released otherwise
// - memory read direction copies peripheral direction input
// - on completion release request, address, strobe and direction together
`timescale 1ns/1ps
`default_nettype none
module bdac_top (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        chipSelect_n,
  input  wire logic        readWrite,
  input  wire logic        regIndexBit,
  input  wire logic        writeStrobe,
  input  wire logic        readStrobe,
  input  wire logic [7:0]  dataIn,
  output logic [7:0]       dataOut,
  output logic             dataOe,
  input  wire logic [11:0] endAddr,
  input  wire logic        periphTransferRequest,
  input  wire logic        periphDirectionRead,
  input  wire logic        busGrant,
  output logic             busRequest,
  output logic             transferAcknowledge,
  output logic             faultFlag,
  output logic             counterLoad,
  output logic [11:0]      addrOut,
  output logic             addrOe,
  output logic             dataStrobe,
  output logic             dataStrobeOe,
  output logic             memoryReadDir,
  output logic             memoryReadDirOe,
  output logic             terminalCount
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int unsigned NSYNC = 17;
  logic [NSYNC-1:0] syncA;
  logic [NSYNC-1:0] syncB;
  logic [NSYNC-1:0] rawIn;

  assign rawIn = {chipSelect_n, readWrite, regIndexBit, writeStrobe, readStrobe,
                  periphTransferRequest, periphDirectionRead, busGrant, 1'b0, dataIn};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      syncA <= '0;
      syncB <= '0;
    end else begin
      syncA <= rawIn;
      syncB <= syncA;
    end
  end

  logic       csN;
  logic       rdWr;
  logic       idxBit;
  logic       wrStb;
  logic       rdStb;
  logic       dmaReq;
  logic       dirRead;
  logic       grant;
  logic [7:0] dataSync;

  assign csN      = syncB[16];
  assign rdWr     = syncB[15];
  assign idxBit   = syncB[14];
  assign wrStb    = syncB[13];
  assign rdStb    = syncB[12];
  assign dmaReq   = syncB[11];
  assign dirRead  = syncB[10];
  assign grant    = syncB[9];
  assign dataSync = syncB[7:0];

  logic wrStbDly;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrStbDly <= 1'b0;
    end else begin
      wrStbDly <= wrStb;
    end
  end

  // ---------------------------------------------------------------
  // register port decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic cs_n, input logic rw, input logic ws,
                               input logic rs, input logic want_read);
    hit = !cs_n && (want_read ? (rw && !ws && rs) : (!rw && !rs));
  endfunction

  logic writeHit;
  logic readHit;
  assign writeHit = wrStb && !wrStbDly && hit(csN, rdWr, wrStb, rdStb, 1'b0);
  assign readHit  = hit(csN, rdWr, wrStb, rdStb, 1'b1);

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic [7:0] startLow_reg;
  logic [7:0] startHigh_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      startLow_reg  <= bdac_pkg::START_LOW_RST;
      startHigh_reg <= bdac_pkg::START_HIGH_RST;
    end else if (writeHit) begin
      if (idxBit == bdac_pkg::IDX_LOW) begin
        startLow_reg <= dataSync;
      end else begin
        startHigh_reg <= dataSync;
      end
    end
  end

  logic        runEnable;
  logic        startLoadRequest;
  logic        countDirection;
  logic        stateReset;
  logic [11:0] startAddr;

  assign runEnable        = startHigh_reg[bdac_pkg::F_RUN];
  assign startLoadRequest = startHigh_reg[bdac_pkg::F_START_LOAD];
  assign countDirection   = startHigh_reg[bdac_pkg::F_COUNT_DIR];
  assign stateReset       = startHigh_reg[bdac_pkg::F_STATE_RST];
  assign startAddr        = {startHigh_reg[bdac_pkg::F_HI_ADDR_LSB +: 4], startLow_reg};

  // ---------------------------------------------------------------
  // control machine
  // ---------------------------------------------------------------
  bdac_pkg::bdac_state_e state_reg;
  bdac_pkg::bdac_state_e state_next;
  logic                  tcInt;

  always_comb begin
    state_next = state_reg;
    if (stateReset) begin
      state_next = bdac_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        bdac_pkg::ST_IDLE: begin
          if (runEnable && startLoadRequest) begin
            state_next = bdac_pkg::ST_PRELOAD;
          end
        end
        bdac_pkg::ST_PRELOAD: begin
          if (!runEnable) begin
            state_next = bdac_pkg::ST_IDLE;
          end else if (dmaReq && !startLoadRequest) begin
            state_next = bdac_pkg::ST_BUSREQ;
          end
        end
        bdac_pkg::ST_BUSREQ: begin
          if (!dmaReq) begin
            state_next = bdac_pkg::ST_FAULT;
          end else if (grant) begin
            state_next = bdac_pkg::ST_MOVING;
          end
        end
        bdac_pkg::ST_MOVING: begin
          if (tcInt) begin
            state_next = bdac_pkg::ST_IDLE;
          end else if (!dmaReq) begin
            state_next = bdac_pkg::ST_FAULT;
          end
        end
        bdac_pkg::ST_FAULT: begin
          state_next = bdac_pkg::ST_FAULT;
        end
        default: begin
          state_next = bdac_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= bdac_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  logic [3:0] stateBits;
  assign stateBits = state_reg;

  // state bits are the outputs themselves
  assign busRequest          = stateBits[3];
  assign transferAcknowledge = stateBits[2];
  assign faultFlag           = stateBits[1];
  assign counterLoad         = stateBits[0];

  // ---------------------------------------------------------------
  // address generator
  // ---------------------------------------------------------------
  logic [11:0] addrCount;

  bdac_addr_counter u_counter (
    .clk            (clk),
    .nrst           (nrst),
    .counterLoad    (counterLoad),
    .transferAck    (transferAcknowledge),
    .countDirection (countDirection),
    .startAddr      (startAddr),
    .endAddr        (endAddr),
    .addrCount      (addrCount),
    .terminalCount  (tcInt)
  );

  assign terminalCount = tcInt;

  // counter flip-flops drive the address bus directly, no extra lag
  assign addrOut = addrCount;

  // ---------------------------------------------------------------
  // bus outputs
  // ---------------------------------------------------------------
  logic driveBus;
  assign driveBus = (state_next == bdac_pkg::ST_MOVING);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addrOe          <= 1'b0;
      memoryReadDir   <= 1'b0;
      memoryReadDirOe <= 1'b0;
      dataStrobeOe    <= 1'b0;
    end else begin
      addrOe          <= driveBus;
      memoryReadDir   <= dirRead;
      memoryReadDirOe <= driveBus;
      dataStrobeOe    <= driveBus;
    end
  end

  // strobe toggles each edge: one period per two clocks
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dataStrobe <= 1'b0;
    end else if (driveBus) begin
      dataStrobe <= !dataStrobe;
    end else begin
      dataStrobe <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // status read path
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dataOut <= 8'h00;
      dataOe  <= 1'b0;
    end else begin
      dataOe <= readHit;
      if (idxBit == bdac_pkg::IDX_LOW) begin
        dataOut <= addrCount[7:0];
      end else begin
        dataOut <= {3'h0, faultFlag, addrCount[11:8]};
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_idle_to_preload : assert property (@(posedge clk) disable iff (!nrst)
    (state_reg == bdac_pkg::ST_IDLE && runEnable && startLoadRequest && !stateReset)
    |=> state_reg == bdac_pkg::ST_PRELOAD)
    else $error("idle did not move to preload");

  a_preload_exit : assert property (@(posedge clk) disable iff (!nrst)
    (state_reg == bdac_pkg::ST_PRELOAD && !runEnable && !stateReset)
    |=> state_reg == bdac_pkg::ST_IDLE)
    else $error("preload did not return to idle");

  a_busreq_fault : assert property (@(posedge clk) disable iff (!nrst)
    (busRequest && !transferAcknowledge && !dmaReq && !stateReset)
    |=> state_reg == bdac_pkg::ST_FAULT)
    else $error("request drop missed during bus request");

  a_tc_priority : assert property (@(posedge clk) disable iff (!nrst)
    (state_reg == bdac_pkg::ST_MOVING && tcInt && !stateReset)
    |=> state_reg == bdac_pkg::ST_IDLE)
    else $error("terminal count did not end transfer");

  a_fault_hold : assert property (@(posedge clk) disable iff (!nrst)
    (state_reg == bdac_pkg::ST_FAULT && !stateReset) |=> faultFlag)
    else $error("fault flag dropped without state reset");

  a_state_reset : assert property (@(posedge clk) disable iff (!nrst)
    stateReset |=> state_reg == bdac_pkg::ST_IDLE)
    else $error("state reset did not force idle");

  a_load_start : assert property (@(posedge clk) disable iff (!nrst)
    counterLoad |=> addrCount == $past(startAddr))
    else $error("start address not loaded");

  a_read_drive : assert property (@(posedge clk) disable iff (!nrst)
    dataOe |-> $past(rdStb))
    else $error("data bus driven without read strobe");

  a_release_all : assert property (@(posedge clk) disable iff (!nrst)
    (addrOe == transferAcknowledge) && (dataStrobeOe == addrOe) && (memoryReadDirOe == addrOe))
    else $error("bus outputs not released together");

endmodule
`default_nettype wire

// File: sim/bdac_far_model.sv
// Purpose: far side model, peripheral request plus processor bus grant
// Assumes: bench raises go to start a request
// Notes:   dropAt of zero keeps the request up for the whole run
`timescale 1ns/1ps
`default_nettype none
module bdac_far_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       go,
  input  wire logic       dirRead,
  input  wire logic [3:0] grantDelay,
  input  wire logic [7:0] dropAt,
  input  wire logic       busRequest,
  output logic            periphTransferRequest,
  output logic            periphDirectionRead,
  output logic            busGrant
);
  logic [7:0] ageReg;
  logic [3:0] waitReg;
  logic       dropReg;

  // -------------------------------------------------------------
  // peripheral side
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ageReg  <= 8'h00;
      dropReg <= 1'b0;
    end else if (!go) begin
      ageReg  <= 8'h00;
      dropReg <= 1'b0;
    end else begin
      ageReg <= ageReg + 8'h01;
      if (dropAt != 8'h00 && ageReg == dropAt) begin
        dropReg <= 1'b1;
      end
    end
  end
  assign periphTransferRequest = go & ~dropReg;
  assign periphDirectionRead   = dirRead;

  // -------------------------------------------------------------
  // processor grant, prompt or slow
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitReg <= 4'h0;
    end else if (!busRequest) begin
      waitReg <= 4'h0;
    end else if (waitReg != 4'hf) begin
      waitReg <= waitReg + 4'h1;
    end
  end
  assign busGrant = busRequest & (waitReg >= grantDelay) & (grantDelay != 4'hf);
endmodule
`default_nettype wire

// File: sim/bdac_top_test.sv
// Purpose: self-checking bench for the burst dma address controller
// Assumes: register port driven through synchronisers, strobe held 4 cycles per access
// Notes:   grantDelay of 15 means the grant never comes
`timescale 1ns/1ps
`default_nettype none
module bdac_top_test;
  localparam logic LO = bdac_pkg::IDX_LOW;
  localparam logic HI = bdac_pkg::IDX_HIGH;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        chipSelect_n = 1'b1;
  logic        readWrite = 1'b1;
  logic        regIndexBit = 1'b0;
  logic        writeStrobe = 1'b0;
  logic        readStrobe = 1'b0;
  logic [7:0]  dataIn = 8'h00;
  logic [11:0] endAddr = 12'h000;
  logic        go = 1'b0;
  logic        dirRead = 1'b0;
  logic [3:0]  grantDelay = 4'h0;
  logic [7:0]  dropAt = 8'h00;
  logic [7:0]  dataOut;
  logic [11:0] addrOut;
  logic        dataOe, busRequest, transferAcknowledge, faultFlag, counterLoad, addrOe;
  logic        dataStrobe, dataStrobeOe, memoryReadDir, memoryReadDirOe, terminalCount;
  logic        periphTransferRequest, periphDirectionRead, busGrant;
  int          failCount = 0;
  int          comparisons = 0;

  always #12.5 clk = ~clk;

  bdac_top i_bdac_top (.clk, .nrst, .chipSelect_n, .readWrite, .regIndexBit, .writeStrobe,
    .readStrobe, .dataIn, .dataOut, .dataOe, .endAddr, .periphTransferRequest,
    .periphDirectionRead, .busGrant, .busRequest, .transferAcknowledge, .faultFlag,
    .counterLoad, .addrOut, .addrOe, .dataStrobe, .dataStrobeOe, .memoryReadDir,
    .memoryReadDirOe, .terminalCount);

  bdac_far_model i_bdac_far_model (.clk, .nrst, .go, .dirRead, .grantDelay, .dropAt,
    .busRequest, .periphTransferRequest, .periphDirectionRead, .busGrant);

  // -------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failCount++;
      $display("FAIL %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic check1(input logic seen, input logic exp);
    check({11'h000, seen}, {11'h000, exp});
  endtask

  function automatic logic sigSel(input int w);
    case (w)
      0: return busRequest;
      1: return transferAcknowledge;
      2: return faultFlag;
      default: return counterLoad;
    endcase
  endfunction

  task automatic waitSig(input int w, input logic lvl);
    int i;
    for (i = 0; i < 300 && sigSel(w) !== lvl; i++) tick(1);
    if (i == 300) begin
      failCount++;
      results();
    end
  endtask

  task automatic regWrite(input logic cs, input logic idx, input logic [7:0] d);
    chipSelect_n = cs;
    readWrite = 1'b0;
    regIndexBit = idx;
    dataIn = d;
    writeStrobe = 1'b1;
    tick(4);
    writeStrobe = 1'b0;
    chipSelect_n = 1'b1;
    tick(3);
  endtask

  task automatic regRead(input logic cs, input logic idx, input logic [7:0] exp);
    chipSelect_n = cs;
    readWrite = 1'b1;
    regIndexBit = idx;
    readStrobe = 1'b1;
    tick(4);
    check1(dataOe, ~cs);
    if (!cs) check({4'h0, dataOut}, {4'h0, exp});
    readStrobe = 1'b0;
    chipSelect_n = 1'b1;
    tick(4);
    check1(dataOe, 1'b0);
  endtask

  task automatic runXfer(input logic [11:0] s, input logic [11:0] e, input logic dir,
                         input logic dr, input logic [3:0] gd);
    logic [11:0] a;
    logic        ds;
    int          i;
    int          n;
    endAddr = e;
    dirRead = dr;
    grantDelay = gd;
    dropAt = 8'h00;
    regWrite(1'b0, LO, s[7:0]);
    regWrite(1'b1, LO, 8'hee);
    regWrite(1'b0, HI, {1'b0, dir, 2'h3, s[11:8]});
    waitSig(3, 1'b1);
    regRead(1'b0, LO, s[7:0]);
    regRead(1'b0, HI, {4'h0, s[11:8]});
    regWrite(1'b0, HI, {1'b0, dir, 2'h1, s[11:8]});
    go = 1'b1;
    waitSig(0, 1'b1);
    check({9'h000, transferAcknowledge, faultFlag, counterLoad}, 12'h000);
    waitSig(1, 1'b1);
    a = s;
    n = 0;
    ds = ~dataStrobe;
    for (i = 0; i < 300 && addrOe === 1'b1; i++) begin
      check(addrOut, a);
      check1(dataStrobe, ~ds);
      check1(memoryReadDir, dr);
      check1(busRequest & dataStrobeOe & memoryReadDirOe, 1'b1);
      if (terminalCount === 1'b1) n++;
      ds = dataStrobe;
      a = dir ? a + 12'h001 : a - 12'h001;
      tick(1);
    end
    if (terminalCount === 1'b1) n++;
    check(a, dir ? e + 12'h001 : e - 12'h001);
    check(12'(n), 12'h001);
    check({8'h00, busRequest, transferAcknowledge, dataStrobeOe, memoryReadDirOe}, 12'h000);
    go = 1'b0;
    tick(2);
  endtask

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    tick(2);
    nrst = 1'b1;
    tick(3);
    check({8'h00, busRequest, transferAcknowledge, faultFlag, counterLoad}, 12'h000);
    regRead(1'b1, LO, 8'h00);
    runXfer(12'h310, 12'h315, 1'b1, 1'b1, 4'h0);
    runXfer(12'h020, 12'h01c, 1'b0, 1'b0, 4'h6);
    runXfer(12'hffe, 12'h001, 1'b1, 1'b1, 4'h2);
    regWrite(1'b0, HI, 8'h31);
    waitSig(3, 1'b1);
    regWrite(1'b0, HI, 8'h21);
    waitSig(3, 1'b0);
    check1(busRequest, 1'b0);
    grantDelay = 4'hf;
    dropAt = 8'h08;
    regWrite(1'b0, HI, 8'h31);
    waitSig(3, 1'b1);
    regWrite(1'b0, HI, 8'h11);
    go = 1'b1;
    waitSig(2, 1'b1);
    tick(10);
    check({9'h000, busRequest, transferAcknowledge, faultFlag}, 12'h001);
    regRead(1'b0, HI, 8'h11);
    go = 1'b0;
    regWrite(1'b0, HI, 8'h80);
    regWrite(1'b0, HI, 8'h00);
    waitSig(2, 1'b0);
    grantDelay = 4'h0;
    dropAt = 8'h14;
    endAddr = 12'h0ff;
    regWrite(1'b0, LO, 8'h00);
    regWrite(1'b0, HI, 8'h70);
    waitSig(3, 1'b1);
    regWrite(1'b0, HI, 8'h50);
    go = 1'b1;
    waitSig(1, 1'b1);
    waitSig(2, 1'b1);
    check({10'h000, addrOe, busRequest}, 12'h000);
    go = 1'b0;
    nrst = 1'b0;
    tick(1);
    check({8'h00, addrOe, dataOe, busRequest, faultFlag}, 12'h000);
    nrst = 1'b1;
    tick(3);
    check({8'h00, busRequest, transferAcknowledge, faultFlag, counterLoad}, 12'h000);
    results();
  end
endmodule
`default_nettype wire
